// ==== rtl/flash_ovrd_pkg.sv ====
package flash_ovrd_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] off_cmd_word0 = 4'h0;
  localparam logic [3:0] off_cmd_word1 = 4'h1;
  localparam logic [3:0] off_cmd_word2 = 4'h2;
  localparam logic [3:0] off_cmd_word3 = 4'h3;
  localparam logic [3:0] off_param_index = 4'h4;
  localparam logic [3:0] off_cmd_status = 4'h5;
  localparam logic [3:0] off_cmd_config = 4'h6;
  localparam logic [3:0] off_error_status = 4'h7;
  localparam logic [3:0] off_error_config = 4'h8;
  localparam logic [3:0] off_pflash_protect = 4'h9;
  localparam logic [3:0] off_eeprom_protect = 4'ha;
  localparam logic [3:0] off_protect_status = 4'hb;
  // command encoding
  localparam logic [7:0] cmd_protect_override = 8'h13;
  localparam logic [15:0] key_invalid = 16'hffff;
  localparam logic [2:0] index_key_only = 3'h1;
  localparam logic [2:0] index_pflash = 3'h2;
  localparam logic [2:0] index_eeprom = 3'h3;
  // cmd_status_reg bits
  localparam int status_cmd_complete = 7;
  localparam int status_access_error = 5;
  localparam int status_protect_violation = 4;
  // cmd_config_reg / error regs bits
  localparam int config_cmd_complete_ie = 7;
  localparam int err_double = 1;
  localparam int err_single = 0;
  // protect_status_reg bit
  localparam int pstat_override_active = 0;
  // reset values
  localparam logic [7:0] pflash_protect_reset = 8'hff;
  localparam logic [7:0] eeprom_protect_reset = 8'hff;
  // execution time of the command, ns
  localparam int exec_time_ns = 100;
  localparam int clk_period_ns = 25;
  localparam int exec_cycles = (exec_time_ns + clk_period_ns - 1) / clk_period_ns;
endpackage

// ==== rtl/flash_ovrd.sv ====
`timescale 1ns/1ps
module flash_ovrd #(
  parameter int exec_cycles = flash_ovrd_pkg::exec_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // system state
  input wire logic [15:0] stored_key,
  input wire logic cmd_allowed,
  input wire logic ecc_double_fault,
  input wire logic ecc_single_fault,
  input wire logic stop_request,
  // outputs
  output logic stop_ack,
  output logic cmd_complete_irq,
  output logic error_irq,
  output logic [7:0] pflash_protect,
  output logic [7:0] eeprom_protect
);
  // refuse counts the 16-bit down counter cannot hold
  if (exec_cycles < 1 || exec_cycles > 65535)
  begin : g_exec_range
    $error("exec_cycles out of range");
  end

  typedef enum logic [1:0] {st_idle, st_busy, st_done} state_e;
  state_e state;

  logic [15:0] cmd_param_words [4];
  logic [2:0] param_index;
  logic cmd_complete_flag;
  logic access_error;
  logic protect_violation;
  logic cmd_complete_irq_en;
  logic double_fault_flag;
  logic single_fault_flag;
  logic double_fault_irq_en;
  logic single_fault_irq_en;
  logic [7:0] pflash_protect_reg;
  logic [7:0] eeprom_protect_reg;
  logic override_active;
  logic [7:0] saved_pflash;
  logic [7:0] saved_eeprom;
  logic [15:0] exec_count;
  logic grant_latched;
  logic [15:0] rdata_mux;

  // decode
  wire wr_status = reg_write && reg_addr == flash_ovrd_pkg::off_cmd_status;
  wire launch = wr_status && cmd_complete_flag
    && reg_wdata[flash_ovrd_pkg::status_cmd_complete];
  wire [7:0] cmd_code = cmd_param_words[0][15:8];
  wire [1:0] select = cmd_param_words[0][1:0];
  wire [15:0] key = cmd_param_words[1];
  wire key_valid = key != flash_ovrd_pkg::key_invalid;
  wire stored_valid = stored_key != flash_ovrd_pkg::key_invalid;
  wire key_match = key_valid && stored_valid && key == stored_key;
  wire index_ok = param_index == flash_ovrd_pkg::index_key_only
    || param_index == flash_ovrd_pkg::index_pflash
    || param_index == flash_ovrd_pkg::index_eeprom;
  wire sel_empty_err = select == 2'b00 && (param_index != flash_ovrd_pkg::index_key_only
    || key_valid);
  wire restore_err = !key_match && !override_active;
  wire launch_err = cmd_code != flash_ovrd_pkg::cmd_protect_override || !index_ok
    || !cmd_allowed || sel_empty_err || restore_err;
  wire wr_pflash = select[0] && param_index >= flash_ovrd_pkg::index_pflash;
  wire wr_eeprom = select[1] && param_index >= flash_ovrd_pkg::index_eeprom;
  wire exec_done = state == st_busy && exec_count == 16'h0000;
  wire accept = launch && !launch_err && state == st_idle;

  assign rdata_mux =
    reg_addr == flash_ovrd_pkg::off_cmd_word0 ? cmd_param_words[0] :
    reg_addr == flash_ovrd_pkg::off_cmd_word1 ? cmd_param_words[1] :
    reg_addr == flash_ovrd_pkg::off_cmd_word2 ? cmd_param_words[2] :
    reg_addr == flash_ovrd_pkg::off_cmd_word3 ? cmd_param_words[3] :
    reg_addr == flash_ovrd_pkg::off_param_index ? {13'h0000, param_index} :
    reg_addr == flash_ovrd_pkg::off_cmd_status ?
      {8'h00, cmd_complete_flag, 1'b0, access_error, protect_violation, 4'h0} :
    reg_addr == flash_ovrd_pkg::off_cmd_config ? {8'h00, cmd_complete_irq_en, 7'h00} :
    reg_addr == flash_ovrd_pkg::off_error_status ?
      {14'h0000, double_fault_flag, single_fault_flag} :
    reg_addr == flash_ovrd_pkg::off_error_config ?
      {14'h0000, double_fault_irq_en, single_fault_irq_en} :
    reg_addr == flash_ovrd_pkg::off_pflash_protect ? {8'h00, pflash_protect_reg} :
    reg_addr == flash_ovrd_pkg::off_eeprom_protect ? {8'h00, eeprom_protect_reg} :
    reg_addr == flash_ovrd_pkg::off_protect_status ? {15'h0000, override_active} :
    16'h0000;

  // parameter words, index, config
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cmd_param_words <= '{default: 16'h0000};
      param_index <= 3'h0;
      cmd_complete_irq_en <= 1'b0;
      double_fault_irq_en <= 1'b0;
      single_fault_irq_en <= 1'b0;
    end
    else if (reg_write && cmd_complete_flag)
    begin
      if (reg_addr <= flash_ovrd_pkg::off_cmd_word3)
        cmd_param_words[reg_addr[1:0]] <= reg_wdata;
      if (reg_addr == flash_ovrd_pkg::off_param_index)
        param_index <= reg_wdata[2:0];
      if (reg_addr == flash_ovrd_pkg::off_cmd_config)
        cmd_complete_irq_en <= reg_wdata[flash_ovrd_pkg::config_cmd_complete_ie];
      if (reg_addr == flash_ovrd_pkg::off_error_config)
      begin
        double_fault_irq_en <= reg_wdata[flash_ovrd_pkg::err_double];
        single_fault_irq_en <= reg_wdata[flash_ovrd_pkg::err_single];
      end
    end
  end

  // sequencer; keeps running in wait mode
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= st_idle;
      cmd_complete_flag <= 1'b1;
      exec_count <= 16'h0000;
      grant_latched <= 1'b0;
    end
    else
    begin
      case (state)
        st_idle:
          if (accept)
          begin
            cmd_complete_flag <= 1'b0;
            exec_count <= 16'(exec_cycles - 1);
            grant_latched <= key_match;
            state <= st_busy;
          end
        st_busy:
          if (exec_done)
            state <= st_done;
          else
            exec_count <= exec_count - 16'h0001;
        st_done:
        begin
          cmd_complete_flag <= 1'b1;
          state <= st_idle;
        end
        default:
          state <= st_idle;
      endcase
    end
  end

  // error flags: launch error sets access_error only, write-one-to-clear, set wins; protect_violation is never set
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      access_error <= 1'b0;
      protect_violation <= 1'b0;
    end
    else
    begin
      if (launch && launch_err)
        access_error <= 1'b1;
      else if (wr_status && reg_wdata[flash_ovrd_pkg::status_access_error])
        access_error <= 1'b0;
      if (wr_status && reg_wdata[flash_ovrd_pkg::status_protect_violation])
        protect_violation <= 1'b0;
    end
  end

  // ecc fault flags, set wins over clear
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
    end
    else
    begin
      if (ecc_double_fault)
        double_fault_flag <= 1'b1;
      else if (reg_write && reg_addr == flash_ovrd_pkg::off_error_status
          && reg_wdata[flash_ovrd_pkg::err_double])
        double_fault_flag <= 1'b0;
      if (ecc_single_fault)
        single_fault_flag <= 1'b1;
      else if (reg_write && reg_addr == flash_ovrd_pkg::off_error_status
          && reg_wdata[flash_ovrd_pkg::err_single])
        single_fault_flag <= 1'b0;
    end
  end

  // protection registers and single-entry save buffer
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pflash_protect_reg <= flash_ovrd_pkg::pflash_protect_reset;
      eeprom_protect_reg <= flash_ovrd_pkg::eeprom_protect_reset;
      saved_pflash <= flash_ovrd_pkg::pflash_protect_reset;
      saved_eeprom <= flash_ovrd_pkg::eeprom_protect_reset;
      override_active <= 1'b0;
    end
    else if (exec_done)
    begin
      if (grant_latched)
      begin
        saved_pflash <= pflash_protect_reg;
        saved_eeprom <= eeprom_protect_reg;
        if (wr_pflash)
          pflash_protect_reg <= cmd_param_words[2][7:0];
        if (wr_eeprom)
          eeprom_protect_reg <= cmd_param_words[3][7:0];
        override_active <= 1'b1;
      end
      else
      begin
        pflash_protect_reg <= saved_pflash;
        eeprom_protect_reg <= saved_eeprom;
        override_active <= 1'b0;
      end
    end
    else if (reg_write && cmd_complete_flag)
    begin
      if (reg_addr == flash_ovrd_pkg::off_pflash_protect)
        pflash_protect_reg <= reg_wdata[7:0];
      if (reg_addr == flash_ovrd_pkg::off_eeprom_protect)
        eeprom_protect_reg <= reg_wdata[7:0];
    end
  end

  // outputs, all registered
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 16'h0000;
      cmd_complete_irq <= 1'b0;
      error_irq <= 1'b0;
      stop_ack <= 1'b0;
      pflash_protect <= flash_ovrd_pkg::pflash_protect_reset;
      eeprom_protect <= flash_ovrd_pkg::eeprom_protect_reset;
    end
    else
    begin
      reg_rdata <= reg_read ? rdata_mux : 16'h0000;
      cmd_complete_irq <= cmd_complete_flag && cmd_complete_irq_en;
      error_irq <= (double_fault_flag && double_fault_irq_en)
        || (single_fault_flag && single_fault_irq_en);
      stop_ack <= stop_request && cmd_complete_flag && state == st_idle && !accept;
      pflash_protect <= pflash_protect_reg;
      eeprom_protect <= eeprom_protect_reg;
    end
  end

  // busy window length, helper for the timing checks
  logic [16:0] busy_len;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      busy_len <= 17'h00000;
    else if (cmd_complete_flag)
      busy_len <= 17'h00000;
    else
      busy_len <= busy_len + 17'h00001;
  end

  // launch acceptance and refusal
  a_error_no_change: assert property (@(posedge mclk) disable iff (reset)
    launch && launch_err && state == st_idle |=> $stable(pflash_protect_reg)
      && $stable(eeprom_protect_reg) && access_error)
    else $error("protection changed on rejected launch");
  a_launch_busy: assert property (@(posedge mclk) disable iff (reset)
    launch && !launch_err && state == st_idle |=> !cmd_complete_flag)
    else $error("complete flag not cleared on launch");
  a_reject_idle: assert property (@(posedge mclk) disable iff (reset)
    launch && launch_err |=> cmd_complete_flag && state == st_idle)
    else $error("rejected launch started a command");
  a_index_err: assert property (@(posedge mclk) disable iff (reset)
    launch && !index_ok |=> access_error)
    else $error("bad index not flagged");
  a_mode_err: assert property (@(posedge mclk) disable iff (reset)
    launch && !cmd_allowed |=> access_error)
    else $error("refused mode not flagged");
  a_restore_err: assert property (@(posedge mclk) disable iff (reset)
    launch && restore_err |=> access_error)
    else $error("restore without buffer not flagged");
  a_select_err: assert property (@(posedge mclk) disable iff (reset)
    launch && sel_empty_err |=> access_error)
    else $error("empty selection not flagged");

  // grant, restore and buffer
  a_erased_no_grant: assert property (@(posedge mclk) disable iff (reset)
    accept && stored_key == flash_ovrd_pkg::key_invalid |=> !grant_latched)
    else $error("override granted with erased key");
  a_grant_sets_active: assert property (@(posedge mclk) disable iff (reset)
    exec_done && grant_latched |=> override_active
      && saved_pflash == $past(pflash_protect_reg))
    else $error("grant did not save and set active");
  a_keep_pflash: assert property (@(posedge mclk) disable iff (reset)
    exec_done && grant_latched && !wr_pflash |=> $stable(pflash_protect_reg))
    else $error("unselected pflash protection changed");
  a_keep_eeprom: assert property (@(posedge mclk) disable iff (reset)
    exec_done && grant_latched && !wr_eeprom |=> $stable(eeprom_protect_reg))
    else $error("unselected eeprom protection changed");
  a_restore_loads: assert property (@(posedge mclk) disable iff (reset)
    exec_done && !grant_latched |=> !override_active
      && pflash_protect_reg == $past(saved_pflash)
      && eeprom_protect_reg == $past(saved_eeprom))
    else $error("restore did not load buffer");
  a_busy_bounded: assert property (@(posedge mclk) disable iff (reset)
    !cmd_complete_flag |-> busy_len <= 17'(exec_cycles))
    else $error("command runs too long");
  a_busy_length: assert property (@(posedge mclk) disable iff (reset)
    cmd_complete_flag && busy_len != 17'h00000 |-> busy_len == 17'(exec_cycles + 1))
    else $error("command length wrong");

  // interrupts, faults and stop
  a_complete_irq: assert property (@(posedge mclk) disable iff (reset)
    ##1 cmd_complete_irq == $past(cmd_complete_flag && cmd_complete_irq_en))
    else $error("complete irq mismatch");
  a_error_irq: assert property (@(posedge mclk) disable iff (reset)
    ecc_double_fault && double_fault_irq_en |-> ##2 error_irq)
    else $error("error irq missing");
  a_single_irq: assert property (@(posedge mclk) disable iff (reset)
    ecc_single_fault && single_fault_irq_en |-> ##2 error_irq)
    else $error("single fault irq missing");
  a_double_flag: assert property (@(posedge mclk) disable iff (reset)
    ecc_double_fault |=> double_fault_flag)
    else $error("double fault flag not set");
  a_single_flag: assert property (@(posedge mclk) disable iff (reset)
    ecc_single_fault |=> single_fault_flag)
    else $error("single fault flag not set");
  a_stop_hold: assert property (@(posedge mclk) disable iff (reset)
    !cmd_complete_flag |=> !stop_ack)
    else $error("stop acknowledged during command");
  a_stop_idle_ack: assert property (@(posedge mclk) disable iff (reset)
    stop_request && cmd_complete_flag && state == st_idle && !accept |=> stop_ack)
    else $error("stop not acknowledged while idle");
  c_grant: cover property (@(posedge mclk) exec_done && grant_latched);
  c_restore: cover property (@(posedge mclk) exec_done && !grant_latched);
  c_reject: cover property (@(posedge mclk) launch && launch_err);
  c_stop_wait: cover property (@(posedge mclk) stop_request && !cmd_complete_flag);
  c_error_irq: cover property (@(posedge mclk) error_irq);
endmodule

// ==== tb/flash_ovrd_tb_top.sv ====
`timescale 1ns/1ps
module flash_ovrd_tb_top;
  logic mclk;
  logic reset;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic [15:0] stored_key;
  logic cmd_allowed;
  logic ecc_double_fault;
  logic ecc_single_fault;
  logic stop_request;
  logic stop_ack;
  logic cmd_complete_irq;
  logic error_irq;
  logic [7:0] pflash_protect;
  logic [7:0] eeprom_protect;
  int n_fail;
  int n_compared;
  logic [15:0] rv;
  // launch cases that must be refused
  logic [7:0] e_code [8] = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h12};
  logic [1:0] e_sel [8] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
  logic [2:0] e_idx [8] = '{3'h0, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2};
  logic [15:0] e_key [8] = '{16'h5a3c, 16'h5a3c, 16'h5a3c, 16'h5a3c, 16'h5a3c, 16'h1111,
    16'hffff, 16'h5a3c};

  flash_ovrd #(.exec_cycles(4)) u_flash_ovrd (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .stored_key(stored_key), .cmd_allowed(cmd_allowed), .ecc_double_fault(ecc_double_fault),
    .ecc_single_fault(ecc_single_fault), .stop_request(stop_request), .stop_ack(stop_ack),
    .cmd_complete_irq(cmd_complete_irq), .error_irq(error_irq),
    .pflash_protect(pflash_protect), .eeprom_protect(eeprom_protect)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    rv = reg_rdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic setup(input logic [7:0] code, input logic [1:0] sel, input logic [15:0] key,
    input logic [7:0] pv, input logic [7:0] ev, input logic [2:0] idx);
    wr(flash_ovrd_pkg::off_cmd_word0, {code, 6'h0, sel});
    wr(flash_ovrd_pkg::off_cmd_word1, key);
    wr(flash_ovrd_pkg::off_cmd_word2, {8'h0, pv});
    wr(flash_ovrd_pkg::off_cmd_word3, {8'h0, ev});
    wr(flash_ovrd_pkg::off_param_index, {13'h0, idx});
  endtask

  // launch, then poll the complete flag with a bounded count
  task automatic go(input logic acc);
    int i;
    wr(flash_ovrd_pkg::off_cmd_status, 16'h0080);
    rd(flash_ovrd_pkg::off_cmd_status);
    chk({15'h0, rv[7]}, {15'h0, ~acc});
    @(negedge mclk);
    chk({15'h0, stop_ack}, {15'h0, stop_request & ~acc});
    i = 0;
    while (rv[7] !== 1'b1 && i <= 30)
    begin
      i++;
      rd(flash_ovrd_pkg::off_cmd_status);
    end
    if (rv[7] !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t command never completed", $time);
      stop_test();
    end
  endtask

  task automatic t_errors;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      stored_key <= (i == 6) ? 16'hffff : 16'h5a3c;
      cmd_allowed <= (i != 2);
      setup(e_code[i], e_sel[i], e_key[i], 8'h00, 8'h00, e_idx[i]);
      go(1'b0);
      chk({15'h0, rv[5]}, 16'h0001);
      chk({pflash_protect, eeprom_protect}, 16'hffff);
      wr(flash_ovrd_pkg::off_cmd_status, 16'h0020);
      rd(flash_ovrd_pkg::off_cmd_status);
      chk({15'h0, rv[5]}, 16'h0000);
    end
    @(posedge mclk);
    stored_key <= 16'h5a3c;
    cmd_allowed <= 1'b1;
    $display("test refused launches done");
  endtask

  task automatic t_override;
    setup(8'h13, 2'h1, 16'h5a3c, 8'h0f, 8'h00, 3'h2);
    go(1'b1);
    chk({pflash_protect, eeprom_protect}, 16'h0fff);
    rd(flash_ovrd_pkg::off_protect_status);
    chk({15'h0, rv[0]}, 16'h0001);
    setup(8'h13, 2'h3, 16'h5a3c, 8'h3c, 8'ha5, 3'h3);
    go(1'b1);
    chk({pflash_protect, eeprom_protect}, 16'h3ca5);
    wr(flash_ovrd_pkg::off_pflash_protect, 16'h0055);
    setup(8'h13, 2'h1, 16'h1111, 8'h00, 8'h00, 3'h1);
    go(1'b1);
    chk({pflash_protect, eeprom_protect}, 16'h0fff);
    rd(flash_ovrd_pkg::off_protect_status);
    chk({15'h0, rv[0]}, 16'h0000);
    setup(8'h13, 2'h2, 16'h5a3c, 8'h00, 8'h33, 3'h3);
    go(1'b1);
    chk({pflash_protect, eeprom_protect}, 16'h0f33);
    setup(8'h13, 2'h0, 16'hffff, 8'h00, 8'h00, 3'h1);
    go(1'b1);
    chk({15'h0, rv[5]}, 16'h0000);
    chk({pflash_protect, eeprom_protect}, 16'h0fff);
    $display("test override and restore done");
  endtask

  task automatic t_stop;
    @(posedge mclk);
    stop_request <= 1'b1;
    settle();
    chk({15'h0, stop_ack}, 16'h0001);
    setup(8'h13, 2'h1, 16'h5a3c, 8'hf0, 8'h00, 3'h2);
    go(1'b1);
    settle();
    chk({15'h0, stop_ack}, 16'h0001);
    chk({8'h0, pflash_protect}, 16'h00f0);
    @(posedge mclk);
    stop_request <= 1'b0;
    $display("test stop during command done");
  endtask

  task automatic t_erased_key;
    @(posedge mclk);
    stored_key <= 16'hffff;
    setup(8'h13, 2'h1, 16'h5a3c, 8'h77, 8'h00, 3'h2);
    go(1'b1);
    chk({pflash_protect, eeprom_protect}, 16'h0fff);
    rd(flash_ovrd_pkg::off_protect_status);
    chk({15'h0, rv[0]}, 16'h0000);
    @(posedge mclk);
    stored_key <= 16'h5a3c;
    $display("test erased stored key done");
  endtask

  task automatic pulse(input logic dbl);
    @(posedge mclk);
    ecc_double_fault <= dbl;
    ecc_single_fault <= ~dbl;
    @(posedge mclk);
    ecc_double_fault <= 1'b0;
    ecc_single_fault <= 1'b0;
    settle();
  endtask

  task automatic t_irq;
    wr(flash_ovrd_pkg::off_cmd_config, 16'h0080);
    settle();
    chk({15'h0, cmd_complete_irq}, 16'h0001);
    wr(flash_ovrd_pkg::off_cmd_config, 16'h0000);
    settle();
    chk({15'h0, cmd_complete_irq}, 16'h0000);
    wr(flash_ovrd_pkg::off_error_config, 16'h0002);
    pulse(1'b1);
    chk({15'h0, error_irq}, 16'h0001);
    rd(flash_ovrd_pkg::off_error_status);
    chk(rv, 16'h0002);
    wr(flash_ovrd_pkg::off_error_status, 16'h0002);
    pulse(1'b0);
    chk({15'h0, error_irq}, 16'h0000);
    rd(flash_ovrd_pkg::off_error_status);
    chk(rv, 16'h0001);
    wr(flash_ovrd_pkg::off_error_config, 16'h0001);
    pulse(1'b0);
    chk({15'h0, error_irq}, 16'h0001);
    $display("test interrupts done");
  endtask

  initial
  begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    stored_key = 16'h5a3c;
    cmd_allowed = 1'b1;
    ecc_double_fault = 1'b0;
    ecc_single_fault = 1'b0;
    stop_request = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    settle();
    chk({pflash_protect, eeprom_protect},
      {flash_ovrd_pkg::pflash_protect_reset, flash_ovrd_pkg::eeprom_protect_reset});
    rd(flash_ovrd_pkg::off_cmd_status);
    chk({15'h0, rv[7]}, 16'h0001);
    t_errors();
    t_override();
    t_stop();
    t_erased_key();
    t_irq();
    stop_test();
  end
endmodule
